// ### rtl/ssam_attr_map.sv
// Legacy segment attribute registers and access routing decode
`timescale 1ns/100ps
`include "ssam_defs.svh"

module ssam_attr_map (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration port
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  // Processor access request
  input wire logic host_req,
  input wire logic host_write,
  input wire logic host_code,
  input wire logic [31:0] host_addr,
  // Processor access routing answer
  output logic host_ack,
  output logic host_to_dram,
  output logic host_to_pci,
  output logic host_l1_cacheable,
  output logic host_l2_alloc,
  // PCI master access request
  input wire logic pci_req,
  input wire logic pci_write,
  input wire logic [31:0] pci_addr,
  // PCI master claim answer
  output logic pci_ack,
  output logic pci_claim
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] attr_r [`SSAM_ATTR_REGS];
  logic [`SSAM_FIELD_W-1:0] fld [`SSAM_FIELDS];
  logic cfg_hit;
  logic [7:0] rd_sel;
  logic [7:0] cfg_rdata_r;
  ssam_pkg::ssam_region_t h_region;
  ssam_pkg::ssam_field_t h_field;
  ssam_pkg::ssam_region_t p_region;
  ssam_pkg::ssam_field_t p_field;
  logic [`SSAM_FIELD_W-1:0] h_attr;
  logic [`SSAM_FIELD_W-1:0] p_attr;
  ssam_pkg::ssam_rw_state_t h_state;
  logic h_dram_nxt;
  logic h_l1_nxt;
  logic h_l2_nxt;
  logic p_claim_nxt;
  logic host_ack_r;
  logic host_to_dram_r;
  logic host_l1_r;
  logic host_l2_r;
  logic pci_ack_r;
  logic pci_claim_r;

  // Read-route and write-route pair to one of four states
  function automatic ssam_pkg::ssam_rw_state_t rw_state(
    input logic [`SSAM_FIELD_W-1:0] a
  );
    logic [1:0] rw;
    rw = {a[`SSAM_BIT_WR], a[`SSAM_BIT_RD]};
    unique case (rw)
      2'h0: rw_state = ssam_pkg::SSAM_ST_DISABLED;
      2'h1: rw_state = ssam_pkg::SSAM_ST_RONLY;
      2'h2: rw_state = ssam_pkg::SSAM_ST_WONLY;
      2'h3: rw_state = ssam_pkg::SSAM_ST_RW;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Attribute registers
  assign cfg_hit = (cfg_addr >= `SSAM_ATTR_OFS_FIRST) &&
                   (cfg_addr <= `SSAM_ATTR_OFS_LAST);

  generate
    for (genvar i = 0; i < `SSAM_ATTR_REGS; i++) begin : g_reg
      // Whole byte stored, reserved bits read back as written
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          attr_r[i] <= `SSAM_ATTR_RESET;
        end else if (cfg_wr &&
                     cfg_addr == `SSAM_ATTR_OFS_FIRST + 8'(i)) begin
          attr_r[i] <= cfg_wdata;
        end
      end
      // Low nibble is the lower-addressed segment
      assign fld[2*i] = attr_r[i][`SSAM_FIELD_W-1:0];
      assign fld[2*i+1] = attr_r[i][7:`SSAM_FIELD_W];
    end
  endgenerate

  // Read mux, unmapped offsets answer zero
  always_comb begin
    rd_sel = 8'h00;
    for (int i = 0; i < `SSAM_ATTR_REGS; i++) begin
      if (cfg_addr == `SSAM_ATTR_OFS_FIRST + 8'(i)) begin
        rd_sel = attr_r[i];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_r <= 8'h00;
    end else begin
      cfg_rdata_r <= cfg_rd ? rd_sel : 8'h00;
    end
  end
  assign cfg_rdata = cfg_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address lookups, one per requester
  ssam_seg_lookup u_host_lookup (
    .addr(host_addr),
    .region(h_region),
    .field(h_field)
  );

  ssam_seg_lookup u_pci_lookup (
    .addr(pci_addr),
    .region(p_region),
    .field(p_field)
  );

  // Field 0 is reserved; the lookup never selects it for a segment
  assign h_attr = fld[h_field];
  assign p_attr = fld[p_field];
  assign h_state = rw_state(h_attr);

  ////////////////////////////////////////////////////////////////////////////
  // Processor routing decode
  always_comb begin
    h_dram_nxt = 1'b1;
    h_l1_nxt = 1'b1;
    h_l2_nxt = 1'b1;
    unique case (h_region)
      ssam_pkg::SSAM_REG_DOS: begin
        h_dram_nxt = 1'b1;
      end
      // Video buffer always goes out and is never cached
      ssam_pkg::SSAM_REG_VIDEO: begin
        h_dram_nxt = 1'b0;
        h_l1_nxt = 1'b0;
        h_l2_nxt = 1'b0;
      end
      ssam_pkg::SSAM_REG_SEG: begin
        // Route by the bit for this direction
        h_dram_nxt = host_write ? h_attr[`SSAM_BIT_WR]
                                : h_attr[`SSAM_BIT_RD];
        // Cacheable only when served by DRAM
        h_l1_nxt = h_dram_nxt && h_attr[`SSAM_BIT_CE] &&
                   (h_attr[`SSAM_BIT_WR] || (!host_write && host_code));
        // Per-state second-level handling
        unique case (h_state)
          ssam_pkg::SSAM_ST_DISABLED: h_l2_nxt = 1'b0;
          ssam_pkg::SSAM_ST_RONLY: h_l2_nxt = 1'b0;
          ssam_pkg::SSAM_ST_WONLY: h_l2_nxt = host_write;
          ssam_pkg::SSAM_ST_RW: h_l2_nxt = 1'b1;
        endcase
      end
      // Above 1 MB is ordinary memory as far as this block is concerned
      ssam_pkg::SSAM_REG_OTHER: begin
        h_dram_nxt = 1'b1;
      end
    endcase
  end

  // Answer registered on each request, held until the next one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_to_dram_r <= 1'b1;
      host_l1_r <= 1'b0;
      host_l2_r <= 1'b0;
    end else if (host_req) begin
      host_to_dram_r <= h_dram_nxt;
      host_l1_r <= h_l1_nxt;
      host_l2_r <= h_l2_nxt;
    end
  end

  // Acknowledge pulse one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_ack_r <= 1'b0;
    end else begin
      host_ack_r <= host_req;
    end
  end

  assign host_ack = host_ack_r;
  assign host_to_dram = host_to_dram_r;
  assign host_to_pci = !host_to_dram_r;
  assign host_l1_cacheable = host_l1_r;
  assign host_l2_alloc = host_l2_r;

  ////////////////////////////////////////////////////////////////////////////
  // PCI master claim decode
  always_comb begin
    p_claim_nxt = 1'b0;
    unique case (p_region)
      ssam_pkg::SSAM_REG_DOS: p_claim_nxt = 1'b1;
      // Readable for reads, writeable for writes
      ssam_pkg::SSAM_REG_SEG: p_claim_nxt = pci_write ?
                                 p_attr[`SSAM_BIT_WR] : p_attr[`SSAM_BIT_RD];
      // Video and upper space belong to other decoders
      ssam_pkg::SSAM_REG_VIDEO: p_claim_nxt = 1'b0;
      ssam_pkg::SSAM_REG_OTHER: p_claim_nxt = 1'b0;
    endcase
  end

  // Claim is a pulse, so a refused cycle simply sees no select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pci_ack_r <= 1'b0;
      pci_claim_r <= 1'b0;
    end else begin
      pci_ack_r <= pci_req;
      pci_claim_r <= pci_req && p_claim_nxt;
    end
  end

  assign pci_ack = pci_ack_r;
  assign pci_claim = pci_claim_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking ck @(posedge clk); endclocking
  default disable iff (rst);

  cfg_readback_a: assert property (
    (cfg_wr && cfg_hit) ##1 (cfg_rd && cfg_addr == $past(cfg_addr))
    |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("attribute register read back differs from write");

  cfg_unmapped_a: assert property (
    !(cfg_rd && cfg_hit) |=> cfg_rdata == 8'h00)
    else $error("unmapped or idle read data not zero");

  host_read_route_a: assert property (
    host_req && !host_write && h_region == ssam_pkg::SSAM_REG_SEG
    |=> host_ack && host_to_dram == $past(h_attr[`SSAM_BIT_RD]) &&
        host_to_pci != host_to_dram)
    else $error("processor read routed against read-route bit");

  host_write_route_a: assert property (
    host_req && host_write && h_region == ssam_pkg::SSAM_REG_SEG
    |=> host_to_dram == $past(h_attr[`SSAM_BIT_WR]))
    else $error("processor write routed against write-route bit");

  code_only_l1_a: assert property (
    host_req && !host_write && h_region == ssam_pkg::SSAM_REG_SEG &&
    h_attr[`SSAM_BIT_RD] && h_attr[`SSAM_BIT_CE] && !h_attr[`SSAM_BIT_WR]
    |=> host_l1_cacheable == $past(host_code))
    else $error("read-only cacheable segment wrong for code fetch");

  ronly_no_l2_a: assert property (
    host_req && h_region == ssam_pkg::SSAM_REG_SEG &&
    h_state == ssam_pkg::SSAM_ST_RONLY |=> !host_l2_alloc)
    else $error("read-only segment allocated in second-level cache");

  disabled_to_pci_a: assert property (
    host_req && h_region == ssam_pkg::SSAM_REG_SEG &&
    h_state == ssam_pkg::SSAM_ST_DISABLED
    |=> host_to_pci && !host_l2_alloc && !host_l1_cacheable)
    else $error("disabled segment access not forwarded to PCI");

  wonly_read_a: assert property (
    host_req && !host_write && h_region == ssam_pkg::SSAM_REG_SEG &&
    h_state == ssam_pkg::SSAM_ST_WONLY |=> host_to_pci && !host_l2_alloc)
    else $error("write-only segment read not forwarded to PCI");

  wonly_write_a: assert property (
    host_req && host_write && h_region == ssam_pkg::SSAM_REG_SEG &&
    h_state == ssam_pkg::SSAM_ST_WONLY |=> host_to_dram && host_l2_alloc)
    else $error("write-only segment write not served by DRAM");

  ronly_write_a: assert property (
    host_req && host_write && h_region == ssam_pkg::SSAM_REG_SEG &&
    h_state == ssam_pkg::SSAM_ST_RONLY |=> host_to_pci && !host_l1_cacheable)
    else $error("read-only segment write not forwarded to PCI");

  pci_claim_a: assert property (
    pci_req && p_region == ssam_pkg::SSAM_REG_SEG
    |=> pci_ack && pci_claim == $past(pci_write ? p_attr[`SSAM_BIT_WR]
                                                : p_attr[`SSAM_BIT_RD]))
    else $error("PCI claim disagrees with segment attributes");

  shadow_copy_c: cover property (
    host_req && !host_write && h_state == ssam_pkg::SSAM_ST_WONLY &&
    h_region == ssam_pkg::SSAM_REG_SEG
    ##1 host_req && host_write && h_region == ssam_pkg::SSAM_REG_SEG);

  code_cached_c: cover property (
    host_req && host_code && h_state == ssam_pkg::SSAM_ST_RONLY &&
    h_attr[`SSAM_BIT_CE] ##1 host_l1_cacheable);

  pci_refused_c: cover property (
    pci_req && p_region == ssam_pkg::SSAM_REG_SEG ##1 pci_ack && !pci_claim);

  fw_rw_cached_c: cover property (
    host_req && h_field == `SSAM_FLD_FW &&
    h_state == ssam_pkg::SSAM_ST_RW ##1 host_l2_alloc && host_l1_cacheable);

endmodule // ssam_attr_map

// ### common/ssam_defs.svh
// Constants for the shadow segment attribute map: offsets, fields, bounds
`ifndef SSAM_DEFS_SVH
`define SSAM_DEFS_SVH

// Register window on the configuration port
`define SSAM_ATTR_OFS_FIRST 8'h59
`define SSAM_ATTR_OFS_LAST 8'h5F
`define SSAM_ATTR_RESET 8'h00
`define SSAM_ATTR_REGS 7
`define SSAM_FIELDS 14
`define SSAM_FIELD_W 4

// Bit positions inside one field
`define SSAM_BIT_RD 0
`define SSAM_BIT_WR 1
`define SSAM_BIT_CE 2

// Field numbers: 2*register + nibble
`define SSAM_FLD_RSVD 4'h0
`define SSAM_FLD_FW 4'h1
`define SSAM_FLD_EXP_BASE 4'h2

// Legacy address map bounds
`define SSAM_DOS_TOP 20'hA0000
`define SSAM_VIDEO_TOP 20'hC0000
`define SSAM_FW_NIBBLE 4'hF

`endif

// ### common/ssam_pkg.sv
// Types shared by the shadow segment attribute map files
package ssam_pkg;

  // Class of a legacy address
  typedef enum logic [1:0] {
    SSAM_REG_DOS = 2'h0,
    SSAM_REG_VIDEO = 2'h1,
    SSAM_REG_SEG = 2'h2,
    SSAM_REG_OTHER = 2'h3
  } ssam_region_t;

  // Field number 0..13
  typedef logic [3:0] ssam_field_t;

  // Read/write state of a segment, one-hot
  typedef enum logic [3:0] {
    SSAM_ST_DISABLED = 4'b0001,
    SSAM_ST_RONLY = 4'b0010,
    SSAM_ST_WONLY = 4'b0100,
    SSAM_ST_RW = 4'b1000
  } ssam_rw_state_t;

endpackage

// ### rtl/ssam_seg_lookup.sv
// Address to legacy region and attribute field lookup
`timescale 1ns/100ps
`include "ssam_defs.svh"

module ssam_seg_lookup (
  // Access address
  input wire logic [31:0] addr,
  // Decode result
  output ssam_pkg::ssam_region_t region,
  output ssam_pkg::ssam_field_t field
);

  ////////////////////////////////////////////////////////////////////////////
  // Region class and field number
  always_comb begin
    region = ssam_pkg::SSAM_REG_OTHER;
    field = `SSAM_FLD_RSVD;
    if (addr[31:20] != 12'h000) begin
      region = ssam_pkg::SSAM_REG_OTHER;
    end else if (addr[19:0] < `SSAM_DOS_TOP) begin
      region = ssam_pkg::SSAM_REG_DOS;
    end else if (addr[19:0] < `SSAM_VIDEO_TOP) begin
      region = ssam_pkg::SSAM_REG_VIDEO;
    end else begin
      region = ssam_pkg::SSAM_REG_SEG;
      if (addr[19:16] == `SSAM_FW_NIBBLE) begin
        field = `SSAM_FLD_FW; // One 64 KB segment
      end else begin
        // 16 KB granules from C0000h upward
        field = `SSAM_FLD_EXP_BASE + addr[17:14];
      end
    end
  end

endmodule // ssam_seg_lookup

// ### verification/ssam_far_agent.sv
// Processor and PCI master model issuing one access at a time
`timescale 1ns/100ps

module ssam_far_agent (
  // Clock
  input wire logic clk,
  // Processor request
  output logic host_req,
  output logic host_write,
  output logic host_code,
  output logic [31:0] host_addr,
  // PCI master request
  output logic pci_req,
  output logic pci_write,
  output logic [31:0] pci_addr
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle request lines at time zero
  initial begin
    host_req = 1'b0;
    host_write = 1'b0;
    host_code = 1'b0;
    host_addr = 32'h0000_0000;
    pci_req = 1'b0;
    pci_write = 1'b0;
    pci_addr = 32'h0000_0000;
  end

  // One-cycle processor request; once taken the address is inverted so a
  // stale value can never pass for a held one
  task automatic host_go(input logic wr, input logic code,
                         input logic [31:0] a);
    @(posedge clk);
    host_req <= 1'b1;
    host_write <= wr;
    host_code <= code;
    host_addr <= a;
    @(posedge clk);
    host_req <= 1'b0;
    host_write <= ~wr;
    host_addr <= ~a;
    #1;
  endtask

  // One-cycle PCI master request, same release habit
  task automatic pci_go(input logic wr, input logic [31:0] a);
    @(posedge clk);
    pci_req <= 1'b1;
    pci_write <= wr;
    pci_addr <= a;
    @(posedge clk);
    pci_req <= 1'b0;
    pci_write <= ~wr;
    pci_addr <= ~a;
    #1;
  endtask
endmodule // ssam_far_agent

// ### verification/test_ssam_attr_map.sv
// Self-checking bench for the legacy segment attribute map
`timescale 1ns/100ps

module test_ssam_attr_map;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_rdata;
  logic host_req, host_write, host_code, host_ack;
  logic host_to_dram, host_to_pci, host_l1_cacheable, host_l2_alloc;
  logic [31:0] host_addr, pci_addr;
  logic pci_req, pci_write, pci_ack, pci_claim;
  int mismatches = 0;
  int n_compared = 0;
  logic [7:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  always #10 clk = ~clk;

  ssam_attr_map dut_u (.clk(clk), .rst(rst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_rdata(cfg_rdata), .host_req(host_req), .host_write(host_write),
    .host_code(host_code), .host_addr(host_addr), .host_ack(host_ack),
    .host_to_dram(host_to_dram), .host_to_pci(host_to_pci),
    .host_l1_cacheable(host_l1_cacheable), .host_l2_alloc(host_l2_alloc),
    .pci_req(pci_req), .pci_write(pci_write), .pci_addr(pci_addr),
    .pci_ack(pci_ack), .pci_claim(pci_claim));

  ssam_far_agent agent_u (.clk(clk), .host_req(host_req),
    .host_write(host_write), .host_code(host_code), .host_addr(host_addr),
    .pci_req(pci_req), .pci_write(pci_write), .pci_addr(pci_addr));

  ////////////////////////////////////////////////////////////////////////////
  // Byte compare used for every kind of result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register port: one-cycle strobes, read data only in the next cycle
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask

  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    d = cfg_rdata;
  endtask

  // Write then read the same offset with no idle cycle between strobes
  task automatic cfg_write_read(input logic [7:0] a, input logic [7:0] d,
                                output logic [7:0] q);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    q = cfg_rdata;
  endtask

  // Routing expected from one attribute nibble: ack, dram, pci, l1, l2
  function automatic logic [7:0] exp_route(input logic [3:0] f,
                                           input logic wr, input logic code);
    logic dram;
    logic l1;
    dram = wr ? f[1] : f[0];
    l1 = dram & f[2] & (f[1] | (!wr & code));
    return {3'h0, 1'b1, dram, !dram, l1, dram & f[1]};
  endfunction

  task automatic host_chk(input logic wr, input logic code,
                          input logic [31:0] a, input logic [7:0] exp);
    agent_u.host_go(wr, code, a);
    chk({3'h0, host_ack, host_to_dram, host_to_pci, host_l1_cacheable,
         host_l2_alloc}, exp);
  endtask

  task automatic pci_chk(input logic wr, input logic [31:0] a,
                         input logic exp);
    agent_u.pci_go(wr, a);
    chk({6'h00, pci_ack, pci_claim}, {6'h00, 1'b1, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and unmapped offsets
  task automatic test_reset();
    for (int k = 0; k < 7; k++) begin
      cfg_read(8'h59 + 8'(k), rd_val);
      chk(rd_val, 8'h00);
    end
    cfg_read(8'h58, rd_val);
    chk(rd_val, 8'h00);
    cfg_read(8'h60, rd_val);
    chk(rd_val, 8'h00);
    $display("test_reset done");
  endtask

  // Every bit of every register, reserved bits included, reads back
  task automatic test_regs();
    for (int k = 0; k < 7; k++) cfg_write(8'h59 + 8'(k), 8'hA8 + 8'(k * 17));
    cfg_write(8'h60, 8'hFF);
    cfg_write(8'h58, 8'hFF);
    for (int k = 0; k < 7; k++) begin
      cfg_read(8'h59 + 8'(k), rd_val);
      chk(rd_val, 8'hA8 + 8'(k * 17));
    end
    cfg_read(8'h60, rd_val);
    chk(rd_val, 8'h00);
    cfg_read(8'h58, rd_val);
    chk(rd_val, 8'h00);
    // Back-to-back strobes: the write must be visible to the very next read
    cfg_write_read(8'h5C, 8'h3C, rd_val);
    chk(rd_val, 8'h3C);
    $display("test_regs done");
  endtask

  // All legal encodings on the C4000h segment; cache-enable only ever comes
  // with read-route, and the reserved bit alone must leave it disabled
  task automatic test_modes();
    logic [3:0] enc [7] = '{4'h0, 4'h1, 4'h5, 4'h2, 4'h3, 4'h7, 4'h8};
    for (int i = 0; i < 7; i++) begin
      cfg_write(8'h5A, {enc[i], 4'h3});
      host_chk(1'b0, 1'b0, 32'h000C_7FFC,
               exp_route(enc[i], 1'b0, 1'b0));
      host_chk(1'b0, 1'b1, 32'h000C_4000,
               exp_route(enc[i], 1'b0, 1'b1));
      host_chk(1'b1, 1'b0, 32'h000C_5000,
               exp_route(enc[i], 1'b1, 1'b0));
      pci_chk(1'b0, 32'h000C_4000, enc[i][0]);
      pci_chk(1'b1, 32'h000C_7FFC, enc[i][1]);
    end
    $display("test_modes done");
  endtask

  // Each field owns exactly its own address span
  task automatic test_segments();
    logic [31:0] base;
    logic [31:0] top;
    for (int f = 1; f < 14; f++) begin
      for (int k = 0; k < 7; k++) cfg_write(8'h59 + 8'(k), 8'h00);
      cfg_write(8'h59 + 8'(f / 2), (f % 2) ? 8'h10 : 8'h01);
      base = (f == 1) ? 32'h000F_0000 : 32'h000C_0000 + 32'((f - 2) * 16384);
      top = (f == 1) ? 32'h000F_FFFF : base + 32'h0000_3FFF;
      host_chk(1'b0, 1'b0, base, exp_route(4'h1, 0, 0));
      host_chk(1'b0, 1'b0, top, exp_route(4'h1, 0, 0));
      host_chk(1'b0, 1'b0, base - 1, exp_route(4'h0, 0, 0));
    end
    host_chk(1'b0, 1'b0, 32'h0009_FFFF, 8'h1B);
    host_chk(1'b0, 1'b0, 32'h000A_0000, 8'h14);
    host_chk(1'b1, 1'b0, 32'h0010_0000, 8'h1B);
    pci_chk(1'b1, 32'h0009_0000, 1'b1);
    pci_chk(1'b0, 32'h000B_0000, 1'b0);
    $display("test_segments done");
  endtask

  // ROM copy: write-only to copy, then read-only with cache-enable for
  // execution; no second-level cache is enabled here, so flipping
  // cache-enable is allowed
  task automatic test_shadow();
    cfg_write(8'h59, 8'h20);
    host_chk(1'b0, 1'b0, 32'h000F_8000, 8'h14);
    host_chk(1'b1, 1'b0, 32'h000F_8000, 8'h19);
    cfg_write(8'h59, 8'h50);
    host_chk(1'b0, 1'b1, 32'h000F_8000, 8'h1A);
    host_chk(1'b1, 1'b0, 32'h000F_8000, 8'h14);
    $display("test_shadow done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic wrap_up();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_regs();
    test_modes();
    test_segments();
    test_shadow();
    wrap_up();
  end

  // Watchdog: the tests need about 460 cycles, allow over twenty times that
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule // test_ssam_attr_map
